/* hdl/wwc_consts.svh */
`ifndef WWC_CONSTS_SVH
`define WWC_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define WWC_ADDR_W     24
`define WWC_CFG_OFS    24'h300004
`define WWC_CTRL_OFS   24'h300008
`define WWC_TMR_OFS    24'h30000C
`define WWC_PSL_OFS    24'h300010
`define WWC_PSH_OFS    24'h300014

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define WWC_CFG_RST    8'hFF
`define WWC_CFG_TOP    7
`define WWC_MODE_HI    6
`define WWC_MODE_LO    5
`define WWC_CPS_HI     4
`define WWC_CPS_LO     0
`define WWC_CTRL_SEN   0
`define WWC_CTRL_PSHI  5
`define WWC_CTRL_PSLO  1
`define WWC_PS_POR     5'h0B
`define WWC_CPS_SWSEL  5'h1F
`define WWC_CPS_MAX    5'h12
`define WWC_EXP_BASE   5'h05
`define WWC_CNT_W      23
`define WWC_PRESCALE_COUNT_W    18

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WWC_CLK_HZ     10000000
`define WWC_LF_HZ      31000
`define WWC_LF_DIV     (`WWC_CLK_HZ / `WWC_LF_HZ)

`endif

/* hdl/wwc_core_if.sv */
`timescale 1ns/1ps
interface wwc_core_if;
  logic        lfTick;
  logic        enable;
  logic        run;
  logic [4:0]  expSel;
  logic [22:0] count;
  logic [4:0]  window;
  logic        periodEnd;

  modport ctl (output enable, run, expSel,
               input  lfTick, count, window, periodEnd);
  modport div (output lfTick);
  modport pre (input  lfTick, enable, run, expSel,
               output count, window, periodEnd);
endinterface

/* hdl/wwc_lf_div.sv */
`timescale 1ns/1ps
`include "wwc_consts.svh"
module wwc_lf_div #(
  parameter int DIV = `WWC_LF_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick out
  wwc_core_if.div  core
);
  localparam int W = $clog2(DIV);

  logic [W-1:0] cnt_reg;
  logic         tick_reg;
  wire          wrap = (cnt_reg == W'(DIV - 1));

  // Low-frequency tick, one cycle every DIV clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= wrap ? '0 : W'(cnt_reg + 1'b1);
      tick_reg <= wrap;
    end
  end

  assign core.lfTick = tick_reg;
endmodule

/* hdl/wwc_pkg.sv */
package wwc_pkg;

  // Operating mode encodings
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SW     = 2'h1,
    MODE_AWAKE  = 2'h2,
    MODE_ALWAYS = 2'h3
  } wwc_mode_t;

  // Bus slave states, Gray up to BUS_DONE; the return to BUS_IDLE flips both bits
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_ACCESS = 2'h1,
    BUS_DONE   = 2'h3
  } wwc_bus_t;

  // Ratio exponent from divider select code
  function automatic logic [4:0] ratioExp(input logic [4:0] code);
    ratioExp = (code <= 5'h12) ? 5'(code + 5'h05) : 5'h05;
  endfunction

endpackage

/* hdl/wwc_prescaler.sv */
`timescale 1ns/1ps
`include "wwc_consts.svh"
module wwc_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core link
  wwc_core_if.pre  core
);
  logic [22:0] cnt_reg;
  logic        end_reg;

  // Terminal count; a count left past a shorter period wraps too
  wire [22:0] lastVal = 23'((24'h1 << core.expSel) - 24'h1);
  wire        atLast  = (cnt_reg >= lastVal);
  wire        step    = core.run && core.lfTick;
  wire [22:0] shifted = cnt_reg >> 5'(core.expSel - `WWC_EXP_BASE);

  // Count while running; hold while suspended; clear when off
  always_ff @(posedge clk) begin
    if (rst || !core.enable) begin
      cnt_reg <= '0;
      end_reg <= 1'b0;
    end else begin
      end_reg <= step && atLast;
      if (step) begin
        cnt_reg <= atLast ? '0 : 23'(cnt_reg + 1'b1);
      end
    end
  end

  assign core.count     = cnt_reg;
  assign core.window    = shifted[4:0];
  assign core.periodEnd = end_reg;
endmodule

/* hdl/wwc_top.sv */
`timescale 1ns/1ps
`include "wwc_consts.svh"
module wwc_top #(
  parameter int LF_DIV = `WWC_LF_DIV
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Core sleep status
  input  wire logic        coreSleep,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Watchdog status
  output logic             wdtActive,
  output logic             wdtTimeout
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  wwc_core_if core ();

  wwc_pkg::wwc_bus_t  bus_reg;
  wwc_pkg::wwc_bus_t  bus_next;
  logic [7:0]         cfg_reg;
  logic [7:0]         cfg_next;
  logic               sen_reg;
  logic               sen_next;
  logic [4:0]         psSel_reg;
  logic [4:0]         psSel_next;
  logic [31:0]        rdata_reg;
  logic               ready_reg;
  logic               err_reg;
  logic               active_reg;
  logic               timeout_reg;

  // ---------------------------------------------------------------
  // Leaf modules
  // ---------------------------------------------------------------

  // Low-frequency tick source
  wwc_lf_div #(
    .DIV (LF_DIV)
  ) u_div (
    .clk  (clk),
    .rst  (rst),
    .core (core.div)
  );

  // Prescale counter
  wwc_prescaler u_pre (
    .clk  (clk),
    .rst  (rst),
    .core (core.pre)
  );

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------

  // Mode and period select fields
  wire wwc_pkg::wwc_mode_t opMode =
    wwc_pkg::wwc_mode_t'(cfg_reg[`WWC_MODE_HI:`WWC_MODE_LO]);
  wire [4:0] periodSel = cfg_reg[`WWC_CPS_HI:`WWC_CPS_LO];

  // Divider code: software select only on the all-ones code
  wire [4:0] divCode = (periodSel == `WWC_CPS_SWSEL) ? psSel_reg
                                                     : periodSel;
  wire [4:0] expSel  = wwc_pkg::ratioExp(divCode);

  // Awake mode: suspend counting while the core sleeps
  wire awakeRun = !coreSleep;

  // Enable and run per operating mode
  logic wdtEnable;
  logic wdtRun;
  always_comb begin
    case (opMode)
      wwc_pkg::MODE_ALWAYS: begin
        wdtEnable = 1'b1;
        wdtRun    = 1'b1;
      end
      wwc_pkg::MODE_AWAKE: begin
        wdtEnable = 1'b1;
        wdtRun    = awakeRun;
      end
      wwc_pkg::MODE_SW: begin
        wdtEnable = sen_reg;
        wdtRun    = sen_reg;
      end
      wwc_pkg::MODE_OFF: begin
        wdtEnable = 1'b0;
        wdtRun    = 1'b0;
      end
      default: begin
        wdtEnable = 1'b0;
        wdtRun    = 1'b0;
      end
    endcase
  end

  // Drive the core link
  assign core.enable = wdtEnable;
  assign core.run    = wdtRun;
  assign core.expSel = expSel;

  // ---------------------------------------------------------------
  // Register read views
  // ---------------------------------------------------------------

  // Configuration byte with fixed top bit
  wire [7:0] cfgView = {1'b1, cfg_reg[6:0]};

  // Control register view
  wire [7:0] ctrlView = {2'h0, psSel_reg, sen_reg};

  // Width of the count that software can see
  localparam int PS_W = `WWC_PRESCALE_COUNT_W;

  // One byte of the prescale count, by byte index
  function automatic logic [7:0] countByte(input logic [22:0] cnt,
                                           input int          idx);
    countByte = cnt[idx*8 +: 8];
  endfunction

  // Timer status: window, armed, prescale top bits
  wire [7:0] tmrView = {core.window, active_reg,
                        core.count[PS_W-1:PS_W-2]};

  // Prescale count low and high bytes
  wire [7:0] pslView = countByte(core.count, 0);
  wire [7:0] pshView = countByte(core.count, 1);

  // ---------------------------------------------------------------
  // APB address decode
  // ---------------------------------------------------------------

  // Byte address compare, shared by every register hit
  function automatic logic isReg(input logic [23:0] addr,
                                 input logic [23:0] ofs);
    isReg = (addr == ofs);
  endfunction

  // Register hits
  wire hitCfg  = isReg(paddr, `WWC_CFG_OFS);
  wire hitCtrl = isReg(paddr, `WWC_CTRL_OFS);
  wire hitTmr  = isReg(paddr, `WWC_TMR_OFS);
  wire hitPsl  = isReg(paddr, `WWC_PSL_OFS);
  wire hitPsh  = isReg(paddr, `WWC_PSH_OFS);
  wire hitAny  = hitCfg | hitCtrl | hitTmr | hitPsl | hitPsh;

  // Selected read byte
  wire [7:0] rdByte = hitCfg  ? cfgView  :
                      hitCtrl ? ctrlView :
                      hitTmr  ? tmrView  :
                      hitPsl  ? pslView  :
                      hitPsh  ? pshView  : 8'h00;

  // Transfer phases
  wire accessReq = psel && penable;
  wire xferDone  = accessReq && ready_reg;
  wire wrLane0   = xferDone && pwrite && pstrb[0];

  // Register writes land only on the completing edge
  wire wrCfg  = wrLane0 && hitCfg;
  wire wrCtrl = wrLane0 && hitCtrl;

  // ---------------------------------------------------------------
  // APB handshake state
  // ---------------------------------------------------------------

  // Next state of the slave
  always_comb begin
    case (bus_reg)
      wwc_pkg::BUS_IDLE:
        bus_next = accessReq ? wwc_pkg::BUS_ACCESS : wwc_pkg::BUS_IDLE;
      wwc_pkg::BUS_ACCESS:
        bus_next = wwc_pkg::BUS_DONE;
      wwc_pkg::BUS_DONE:
        bus_next = wwc_pkg::BUS_IDLE;
      default:
        bus_next = wwc_pkg::BUS_IDLE;
    endcase
  end

  // Slave state register
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_reg <= wwc_pkg::BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------

  // Answer values, set as the access phase opens
  wire        startAcc   = (bus_next == wwc_pkg::BUS_ACCESS);
  wire [31:0] rdata_next = (startAcc && !pwrite) ? {24'h00_0000, rdByte}
                                                 : 32'h0000_0000;
  wire        ready_next = startAcc;
  wire        err_next   = startAcc && !hitAny;

  // Ready, one cycle into access
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  // Read data, zero outside a read answer
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Error flag for an unmapped address
  always_ff @(posedge clk) begin
    if (rst) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------

  // Configuration next value; status and count take no writes
  assign cfg_next   = wrCfg  ? {1'b1, pwdata[6:0]} : cfg_reg;

  // Control next values
  assign sen_next   = wrCtrl ? pwdata[`WWC_CTRL_SEN] : sen_reg;
  assign psSel_next = wrCtrl ? pwdata[`WWC_CTRL_PSHI:`WWC_CTRL_PSLO]
                             : psSel_reg;

  // Configuration byte, blank value all ones
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= `WWC_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Control: software enable, off from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sen_reg <= 1'b0;
    end else begin
      sen_reg <= sen_next;
    end
  end

  // Control: divider select, power-on code from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      psSel_reg <= `WWC_PS_POR;
    end else begin
      psSel_reg <= psSel_next;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog status
  // ---------------------------------------------------------------

  // Armed flag, zero from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= wdtEnable;
    end
  end

  // Period-end pulse, zero from reset
  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= core.periodEnd;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // APB answer, straight from flip-flops
  assign prdata     = rdata_reg;
  assign pready     = ready_reg;
  assign pslverr    = err_reg;

  // Watchdog status, straight from flip-flops
  assign wdtActive  = active_reg;
  assign wdtTimeout = timeout_reg;

endmodule

/* testbench/windowed_watchdog_config_test.sv */
`timescale 1ns/1ps
`include "wwc_consts.svh"
module windowed_watchdog_config_test;
  localparam int LFD = 2;
  logic        clk = 0, rst = 1, coreSleep = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [23:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, wdtActive, wdtTimeout, er;
  logic [4:0]  cs [6] = '{5'h00, 5'h01, 5'h04, 5'h13, 5'h1E, 5'h1F};
  int          err_total = 0, comparisons = 0, toCnt = 0, n;
  integer      seed = 79;

  // Clock
  always #50 clk = ~clk;

  wwc_top #(.LF_DIV(LFD)) uut (.clk, .rst, .coreSleep, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .wdtActive, .wdtTimeout);

  // Timeout pulse tally
  always @(posedge clk) if (wdtTimeout === 1'b1) toCnt++;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer, request held until pready
  task apb(input logic w, input logic [23:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Clocks between two timeout pulses, after two settling pulses
  task measure(output int cyc);
    int k;
    for (k = 0; k < 3; k++) begin
      cyc = 0;
      do begin
        @(posedge clk);
        cyc++;
      end while (wdtTimeout !== 1'b1 && cyc < 4000);
    end
    if (cyc >= 4000) begin
      err_total++;
      wrap_up();
    end
  endtask

  // Expected timeout spacing in clocks
  function automatic int gap(input logic [4:0] c, input logic [4:0] sel);
    logic [4:0] e;
    e = (c == 5'h1F) ? sel : c;
    return LFD << ((e <= 5'h12) ? e + 5 : 5);
  endfunction

  // Main sequence
  initial begin
    logic [4:0] c;
    int m, s, z;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, `WWC_CFG_OFS, 0, 0);
    check(rd, 32'h000000FF);
    apb(0, `WWC_CTRL_OFS, 0, 0);
    check(rd, 32'h00000016);
    apb(0, `WWC_TMR_OFS, 0, 0);
    check(rd[2], 1'b1);
    apb(1, `WWC_TMR_OFS, $random(seed), 4'hF);
    check(er, 1'b0);
    apb(0, 24'h300018, 0, 0);
    check(er, 1'b1);
    apb(1, `WWC_CFG_OFS, 0, 4'h0);
    apb(0, `WWC_CFG_OFS, 0, 0);
    check(rd, 32'h000000FF);
    apb(1, `WWC_CFG_OFS, 0, 4'hF);
    apb(0, `WWC_CFG_OFS, 0, 0);
    check(rd, 32'h00000080);
    apb(0, `WWC_TMR_OFS, 0, 0);
    check(rd, 32'h00000000);
    apb(1, `WWC_CFG_OFS, 32'h72, 4'h1);
    apb(0, `WWC_CFG_OFS, 0, 0);
    check(rd, 32'h000000F2);
    // Every mode against enable bit and sleep
    for (m = 0; m < 4; m++)
      for (s = 0; s < 2; s++)
        for (z = 0; z < 2; z++) begin
          coreSleep <= z[0];
          apb(1, `WWC_CTRL_OFS, {26'h0, 5'h0B, s[0]}, 4'h1);
          apb(1, `WWC_CFG_OFS, {24'h0, 1'b1, m[1:0], 5'h00}, 4'h1);
          repeat (5) @(posedge clk);
          n = toCnt;
          repeat (200) @(posedge clk);
          check(wdtActive, m >= 2 || (m == 1 && s == 1));
          check(toCnt != n, m == 3 || (m == 2 && z == 0)
                || (m == 1 && s == 1));
          apb(0, `WWC_PSL_OFS, 0, 0);
          n = rd;
          apb(0, `WWC_PSL_OFS, 0, 0);
          check(rd != n, m == 3 || (m == 2 && z == 0)
                || (m == 1 && s == 1));
          apb(0, `WWC_PSH_OFS, 0, 0);
          check(rd, 32'h00000000);
        end
    // Divide ratios: corners then random
    coreSleep <= 1'b0;
    for (m = 0; m < 9; m++) begin
      c = (m < 6) ? cs[m] : 5'($unsigned($random(seed)) % 5);
      s = $unsigned($random(seed)) % 4;
      apb(1, `WWC_CTRL_OFS, {26'h0, 5'(s), 1'b0}, 4'h1);
      apb(1, `WWC_CFG_OFS, {24'h0, 3'b111, c}, 4'h1);
      measure(n);
      check(n, gap(c, 5'(s)));
      apb(0, `WWC_TMR_OFS, 0, 0);
      check(rd[2:0], 3'b100);
    end
    wrap_up();
  end

  // Hang guard
  initial begin
    #8ms;
    err_total++;
    wrap_up();
  end
endmodule

/* testbench/wwc_top_properties.sv */
`timescale 1ns/1ps
`include "wwc_consts.svh"
module wwc_checker (
  // Clock, reset and core sleep status
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        coreSleep,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Watchdog status
  input wire logic        wdtActive,
  input wire logic        wdtTimeout
);
  wire mapped;
  // Decoded register hit
  assign mapped = paddr inside {`WWC_CFG_OFS, `WWC_CTRL_OFS, `WWC_TMR_OFS,
                                `WWC_PSL_OFS, `WWC_PSH_OFS};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_READY_LATE: assert property (
    psel && penable && !$past(penable) |=> pready)
    else $error("answer not one cycle into access");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_UPPER_ZERO: assert property (
    pready |-> prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  AST_CFG_TOP: assert property (
    pready && !pwrite && paddr == `WWC_CFG_OFS |-> prdata[7])
    else $error("config top bit not one");
  AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("error flag disagrees with map");
  AST_TO_PULSE: assert property (wdtTimeout |=> !wdtTimeout)
    else $error("timeout pulse too long");
  AST_TO_ARMED: assert property (
    wdtTimeout |-> $past(wdtActive, 2))
    else $error("timeout while disarmed");
  AST_TMR_ARMED: assert property (
    pready && !pwrite && $stable(wdtActive) && paddr == `WWC_TMR_OFS
    |-> prdata[2] == wdtActive)
    else $error("armed bit mismatch");
  // Main scenarios
  cover property (pready && pslverr);
  cover property (wdtTimeout);
  cover property (pready && !pwrite && paddr == `WWC_TMR_OFS);
endmodule

bind wwc_top wwc_checker chk (.clk, .rst, .coreSleep, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .wdtActive,
  .wdtTimeout);
